//--- hw/pld_device.sv
// Sum-of-products logic device with ten macrocells, fuse store and programming port.
// Assumes the pins arrive unsynchronised on the link and a programmer on the prog port.
//
// Functional notes
// - Product term enables each three-state output
// - Disabled combinatorial pin acts as input
// - Polarity bit 1 non-inverted, 0 inverted
// - Polarity applies registered and combinatorial alike
// - Preset term loads high next clock
// - Reset term clears flops immediately
// - One preset, one reset shared by cells
// - Preset/reset act on flop, polarity after
// - Power-up clears flops within reset delay
// - Security fuse makes array read all programmed
// - Super level disables outputs, enables preload
// - Tester drives registered pins, floats others
// - Preload clock loads flop from pin
// - Tester releases pins, then drops super
// - Flop captures sum on clock rise
// - Bypass 0 registered, 1 combinatorial feedback
// - Empty term high, contradictory term low
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module pld_device (
    input wire logic mclk,
    input wire logic srst,
    pld_link_if.dev link,
    input wire logic progWrite,
    input wire logic progRead,
    input wire pld_pkg::addr_t progAddr,
    input wire pld_pkg::fuse_row_t progWData,
    output pld_pkg::fuse_row_t progRData,
    output logic secured,
    output logic preloadActive
);
    import pld_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Product term: a set fuse bit is an opened link, so that literal drops out
    function automatic logic pterm(input fuse_row_t fuse, input fuse_row_t lits);
        pterm = &(fuse | lits);
    endfunction : pterm

    // Flat row index for term t of cell c
    function automatic int rowOf(input int c, input int t);
        rowOf = c * ROWS_PER_CELL + t;
    endfunction : rowOf

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; logic reads the second stage, and for the clock also the third
    in_vec_t inMeta_q;
    in_vec_t inSync_q;
    cell_vec_t pinMeta_q;
    cell_vec_t pinSync_q;
    logic clkMeta_q;
    logic clkSync_q;
    logic clkPrev_q;
    logic supMeta_q;
    logic supSync_q;
    // Dedicated inputs
    always_ff @(posedge mclk) begin
        inMeta_q <= link.inPins;
        inSync_q <= inMeta_q;
    end
    // Macrocell pins, read back as bypass feedback and preload data
    always_ff @(posedge mclk) begin
        pinMeta_q <= link.pinLevel;
        pinSync_q <= pinMeta_q;
    end
    // Board clock; the extra stage gives the edge detector its history
    always_ff @(posedge mclk) begin
        clkMeta_q <= link.globalClk;
        clkSync_q <= clkMeta_q;
        clkPrev_q <= clkSync_q;
    end
    // Super level is a slow level, so two stages are enough
    always_ff @(posedge mclk) begin
        supMeta_q <= link.superLvl;
        supSync_q <= supMeta_q;
    end

    // One rising edge of the board clock feeds every cell
    logic clkRise;
    assign clkRise = clkSync_q & ~clkPrev_q;
    assign preloadActive = supSync_q;

    ////////////////////////////////////////////////////////////////////////////
    // Power-up reset: flops held low until the delay has run out
    // Clock rises seen during the hold load zero, as the flops stay cleared
    cnt_t pwrCnt_q;
    logic pwrupHold;
    assign pwrupHold = (pwrCnt_q != cnt_t'(PWRUP_CYC));
    always_ff @(posedge mclk) begin
        if (srst) pwrCnt_q <= '0;
        else if (pwrupHold) pwrCnt_q <= pwrCnt_q + cnt_t'(1);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fuse store; reset models a blank part with every link intact
    fuse_row_t fuse_q [NUM_ROWS];
    cell_vec_t pol_q;
    cell_vec_t byp_q;
    logic sec_q;
    logic rowHit;
    logic cfgHit;
    logic secHit;
    logic wrRow;
    logic wrCfg;
    logic wrSec;
    // Once secured the pattern is frozen as well as hidden
    // Address decode shared by the write and readback paths
    assign rowHit = (32'(progAddr) < NUM_ROWS);
    assign cfgHit = (progAddr == CFG_ADDR);
    assign secHit = (progAddr == SEC_ADDR);
    assign wrRow = progWrite & rowHit & ~sec_q;
    assign wrCfg = progWrite & cfgHit & ~sec_q;
    assign wrSec = progWrite & secHit;
    always_ff @(posedge mclk) begin
        if (srst) begin
            for (int r = 0; r < NUM_ROWS; r++) fuse_q[r] <= '0;
        end else if (wrRow) begin
            fuse_q[progAddr] <= progWData;
        end
    end
    // Configuration bits per cell and the one-way security fuse
    always_ff @(posedge mclk) begin
        if (srst) begin
            pol_q <= POL_RESET;
            byp_q <= BYP_RESET;
            sec_q <= 1'b0;
        end else begin
            if (wrCfg) pol_q <= progWData[POL_LSB +: NUM_CELLS];
            if (wrCfg) byp_q <= progWData[BYP_LSB +: NUM_CELLS];
            if (wrSec && progWData[SEC_BIT]) sec_q <= 1'b1;
        end
    end
    assign secured = sec_q;

    ////////////////////////////////////////////////////////////////////////////
    // Readback; a secured array reads as if every fuse were programmed
    fuse_row_t rdMux;
    fuse_row_t cfgWord;
    fuse_row_t rdData_q;
    assign cfgWord = fuse_row_t'({byp_q, pol_q});
    // Unmapped addresses read zero so a programmer can probe the map safely
    assign rdMux = rowHit ? (sec_q ? '1 : fuse_q[progAddr]) :
                   cfgHit ? cfgWord :
                   secHit ? fuse_row_t'(sec_q) :
                   '0;
    // Data stand only in the cycle after the read strobe
    always_ff @(posedge mclk) begin
        if (srst) rdData_q <= '0;
        else rdData_q <= progRead ? rdMux : '0;
    end
    assign progRData = rdData_q;

    ////////////////////////////////////////////////////////////////////////////
    // Literal vector: true and complement of every input and feedback line
    // Feedback rides above the inputs: literal 11 is cell 0
    cell_vec_t fb;
    logic [NUM_SIGS-1:0] sigs;
    fuse_row_t lits;
    assign sigs = {fb, inSync_q};
    assign lits = {~sigs, sigs};

    // Shared preset and reset terms reach every registered cell
    // The reset term acts through the input synchronisers, so it lands late
    logic arTerm;
    logic spTerm;
    assign arTerm = pterm(fuse_q[AR_ROW], lits);
    assign spTerm = pterm(fuse_q[SP_ROW], lits);

    ////////////////////////////////////////////////////////////////////////////
    // Cells: term 0 is the enable, the rest form the fixed OR sum
    // Intact term rows evaluate low, so an unwritten cell stays disabled
    cell_vec_t oeTerm;
    cell_vec_t sumIn;
    cell_vec_t cellOut;
    cell_vec_t cellOe;
    for (genvar c = 0; c < NUM_CELLS; c++) begin : g_cell
        logic [TERMS_PER_CELL-1:0] hit;
        for (genvar t = 0; t < TERMS_PER_CELL; t++) begin : g_term
            assign hit[t] = pterm(fuse_q[rowOf(c, t + 1)], lits);
        end
        assign oeTerm[c] = pterm(fuse_q[rowOf(c, 0)], lits);
        assign sumIn[c] = |hit;
        output_macrocell u_cell (
            .mclk(mclk),
            .srst(srst),
            .sumIn(sumIn[c]),
            .oeTerm(oeTerm[c]),
            .polarity(pol_q[c]),
            .bypass(byp_q[c]),
            .arTerm(arTerm),
            .spTerm(spTerm),
            .clkRise(clkRise),
            .preload(supSync_q),
            .pwrupHold(pwrupHold),
            .pinIn(pinSync_q[c]),
            .pinOut(cellOut[c]),
            .pinOe(cellOe[c]),
            .feedback(fb[c])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers; a permanently disabled cell leaves its pin to the board
    assign link.devOut = cellOut;
    assign link.devOe = cellOe;
endmodule : pld_device

//--- inc/pld_pkg.sv
// Constants and types shared by the macrocell device, its cells and the board tester.
// Assumes one 25 MHz clock (mclk) on both ends and a synchronous active-high reset.
package pld_pkg;
    // Array geometry
    localparam int NUM_CELLS = 10;
    localparam int NUM_INPUTS = 11;
    localparam int TERMS_PER_CELL = 8;
    localparam int ROWS_PER_CELL = TERMS_PER_CELL + 1;
    localparam int NUM_SIGS = NUM_INPUTS + NUM_CELLS;
    localparam int NUM_LITS = 2 * NUM_SIGS;
    ////////////////////////////////////////////////////////////////////////////
    // Programming map: rows 0..89 cell terms, then the two shared terms
    localparam int ADDR_W = 7;
    localparam int AR_ROW = NUM_CELLS * ROWS_PER_CELL;
    localparam int SP_ROW = AR_ROW + 1;
    localparam int NUM_ROWS = SP_ROW + 1;
    localparam logic [6:0] CFG_ADDR = 7'h5C;
    localparam logic [6:0] SEC_ADDR = 7'h5D;
    localparam int POL_LSB = 0;
    localparam int BYP_LSB = 10;
    localparam int SEC_BIT = 0;
    localparam logic [9:0] POL_RESET = 10'h000;
    localparam logic [9:0] BYP_RESET = 10'h000;
    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int PWRUP_RESET_NS = 1000;
    localparam int PWRUP_CYC = (PWRUP_RESET_NS / CLK_PERIOD_NS < 1) ? 1
                               : PWRUP_RESET_NS / CLK_PERIOD_NS;
    localparam int PRELOAD_DELAY_NS = 100;
    localparam int PRELOAD_CYC = (PRELOAD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 5;
    ////////////////////////////////////////////////////////////////////////////
    typedef logic [NUM_LITS-1:0] fuse_row_t;
    typedef logic [NUM_CELLS-1:0] cell_vec_t;
    typedef logic [NUM_INPUTS-1:0] in_vec_t;
    typedef logic [ADDR_W-1:0] addr_t;
    typedef logic [CNT_W-1:0] cnt_t;
endpackage : pld_pkg

//--- inc/pld_link_if.sv
// Pins between the logic device and the board/tester logic.
// Assumes both ends run on the same mclk; the interface resolves the shared pins.
`timescale 1ns/1ps
interface pld_link_if;
    import pld_pkg::*;
    in_vec_t inPins;      // Dedicated inputs
    logic globalClk;      // global_clock_input
    logic superLvl;       // preload_super_voltage present
    cell_vec_t devOut;
    cell_vec_t devOe;
    cell_vec_t hostOut;
    cell_vec_t hostOe;
    cell_vec_t pinLevel;  // Resolved macrocell_pins
    // Device drive wins; an undriven pin reads low (weak pull-down)
    assign pinLevel = (devOe & devOut) | (~devOe & hostOe & hostOut);
    modport dev (
        input inPins, globalClk, superLvl, pinLevel,
        output devOut, devOe
    );
    modport board (
        input pinLevel,
        output inPins, globalClk, superLvl, hostOut, hostOe
    );
endinterface : pld_link_if

//--- hw/output_macrocell.sv
// One output_macrocell: flip-flop, bypass mux, polarity and three-state control.
// Assumes all inputs are already synchronous to mclk.
`timescale 1ns/1ps
module output_macrocell (
    input wire logic mclk,
    input wire logic srst,
    input wire logic sumIn,
    input wire logic oeTerm,
    input wire logic polarity,
    input wire logic bypass,
    input wire logic arTerm,
    input wire logic spTerm,
    input wire logic clkRise,
    input wire logic preload,
    input wire logic pwrupHold,
    input wire logic pinIn,
    output logic pinOut,
    output logic pinOe,
    output logic feedback
);
    import pld_pkg::*;
    logic state_q;
    logic state_d;
    logic stateVis;
    logic srcLevel;
    logic loadPin;

    ////////////////////////////////////////////////////////////////////////////
    // Reset term masks the stored state at once, the flop follows next edge
    assign stateVis = state_q & ~arTerm;
    assign loadPin = preload & ~bypass;
    // Reset beats preset and array data; power-up hold acts like reset
    assign state_d = (pwrupHold | arTerm) ? 1'b0 :
                     !clkRise ? state_q :
                     loadPin ? pinIn :
                     spTerm ? 1'b1 :
                     sumIn;
    always_ff @(posedge mclk) begin
        if (srst) state_q <= 1'b0;
        else state_q <= state_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Polarity applies after the flop or the bypass path alike
    assign srcLevel = bypass ? sumIn : stateVis;
    assign pinOut = polarity ? srcLevel : ~srcLevel;
    // Preload disables every driver so the tester can force the pins
    assign pinOe = oeTerm & ~preload;
    // Registered cells feed back the inverted flop; taking it after the reset
    // mask would close a loop through the shared reset term, so the array
    // sees an asynchronous clear one mclk late
    assign feedback = bypass ? pinIn : ~state_q;
endmodule : output_macrocell

//--- hw/board_tester.sv
// Board and tester side: drives inputs and clock, runs the preload sequence.
// Assumes the device end sits on the same link and the same mclk.
`timescale 1ns/1ps
module board_tester (
    input wire logic mclk,
    input wire logic srst,
    pld_link_if.board link,
    input wire pld_pkg::in_vec_t inputsValue,
    input wire logic clockReq,
    input wire logic preloadReq,
    input wire pld_pkg::cell_vec_t preloadValue,
    input wire pld_pkg::cell_vec_t preloadMask,
    input wire pld_pkg::cell_vec_t userDrive,
    input wire pld_pkg::cell_vec_t userDriveEn,
    output logic busy,
    output pld_pkg::cell_vec_t sampledPins
);
    import pld_pkg::*;
    typedef enum logic [3:0] {
        IDLE, PULSE_HI, PULSE_LO, PL_RAISE, PL_DRIVE,
        PL_CLKHI, PL_CLKLO, PL_RELEASE, PL_LOWER
    } tester_e;
    tester_e state_q;
    tester_e state_d;
    cnt_t wait_q;
    cell_vec_t plVal_q;
    cell_vec_t plMask_q;
    in_vec_t inVal_q;
    cell_vec_t pinMeta_q;
    cell_vec_t pinSync_q;
    logic stepDone;
    logic plDrive;
    logic plAny;

    ////////////////////////////////////////////////////////////////////////////
    // Each preload step lasts the delay time before the next begins
    assign stepDone = (wait_q == cnt_t'(PRELOAD_CYC - 1));
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            IDLE: begin
                if (preloadReq) state_d = PL_RAISE;
                else if (clockReq) state_d = PULSE_HI;
            end
            PULSE_HI: state_d = PULSE_LO;
            PULSE_LO: state_d = IDLE;
            PL_RAISE: if (stepDone) state_d = PL_DRIVE;
            PL_DRIVE: if (stepDone) state_d = PL_CLKHI;
            PL_CLKHI: if (stepDone) state_d = PL_CLKLO;
            PL_CLKLO: if (stepDone) state_d = PL_RELEASE;
            PL_RELEASE: if (stepDone) state_d = PL_LOWER;
            PL_LOWER: if (stepDone) state_d = IDLE;
        endcase
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_q <= IDLE;
            wait_q <= '0;
        end else begin
            state_q <= state_d;
            wait_q <= (state_d != state_q) ? '0 : wait_q + cnt_t'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request data held for the whole sequence
    always_ff @(posedge mclk) begin
        if (srst) begin
            plVal_q <= '0;
            plMask_q <= '0;
            inVal_q <= '0;
            pinMeta_q <= '0;
            pinSync_q <= '0;
        end else begin
            if (state_q == IDLE && preloadReq) plVal_q <= preloadValue;
            if (state_q == IDLE && preloadReq) plMask_q <= preloadMask;
            inVal_q <= inputsValue;
            pinMeta_q <= link.pinLevel;
            pinSync_q <= pinMeta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Only pins set in the preload mask are forced; the others stay floating
    assign plDrive = (state_q == PL_DRIVE) | (state_q == PL_CLKHI) | (state_q == PL_CLKLO);
    assign plAny = plDrive | (state_q == PL_RAISE) | (state_q == PL_RELEASE)
                   | (state_q == PL_LOWER);
    assign link.hostOe = plDrive ? plMask_q : (plAny ? '0 : userDriveEn);
    assign link.hostOut = plDrive ? plVal_q : userDrive;
    // Super level released only after pins are let go
    assign link.superLvl = plAny & (state_q != PL_LOWER);
    assign link.globalClk = (state_q == PULSE_HI) | (state_q == PL_CLKHI);
    assign link.inPins = inVal_q;
    assign busy = (state_q != IDLE);
    assign sampledPins = pinSync_q;
endmodule : board_tester

//--- tb/pld_link_monitor.sv
// Assertions on the pin link between the logic device and the board tester.
// Assumes one mclk domain, a synchronous active-high srst, and the link signals as inputs.
`timescale 1ns/1ps
module pld_link_monitor (
    input wire logic mclk,
    input wire logic srst,
    input wire pld_pkg::in_vec_t inPins,
    input wire logic globalClk,
    input wire logic superLvl,
    input wire pld_pkg::cell_vec_t devOut,
    input wire pld_pkg::cell_vec_t devOe,
    input wire pld_pkg::cell_vec_t hostOut,
    input wire pld_pkg::cell_vec_t hostOe,
    input wire pld_pkg::cell_vec_t pinLevel
);
    import pld_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    ////////////////////////////////////////
    // Device side: intact fuses and preload both keep the buffers off
    property p_reset_quiet;
        $fell(srst) |-> (devOe == '0) [*3];
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("output enabled right after reset");
    property p_preload_quiet;
        superLvl [*4] |-> devOe == '0;
    endproperty
    a_preload_quiet: assert property (p_preload_quiet)
        else $error("output enabled in preload");
    // Sync delay means the buffers must stay off briefly after the super level drops
    property p_reenable_late;
        $fell(superLvl) |-> devOe == '0 ##1 devOe == '0;
    endproperty
    a_reenable_late: assert property (p_reenable_late)
        else $error("output enabled before preload exit settled");
    // A pin the board drives must never see the device driving it too
    property p_pin_float;
        (devOe & hostOe) == '0;
    endproperty
    a_pin_float: assert property (p_pin_float)
        else $error("device and board drive the same pin");
    ////////////////////////////////////////
    // Tester side: clock and preload step order
    property p_clock_pulse;
        $rose(globalClk) && !superLvl |=> !globalClk;
    endproperty
    a_clock_pulse: assert property (p_clock_pulse)
        else $error("clock pulse not one cycle high");
    property p_preload_clock;
        $rose(superLvl) |-> !globalClk [*6] ##1 globalClk [*3] ##1 !globalClk;
    endproperty
    a_preload_clock: assert property (p_preload_clock)
        else $error("preload clock out of step");
    property p_drive_hold;
        $rose(superLvl) |-> ##4 ($stable(hostOe) && $stable(hostOut)) [*8];
    endproperty
    a_drive_hold: assert property (p_drive_hold)
        else $error("preload drive not held over clock");
    property p_release_first;
        $rose(superLvl) |-> ##12 (superLvl && hostOe == '0) [*3] ##1 !superLvl;
    endproperty
    a_release_first: assert property (p_release_first)
        else $error("super level dropped before pins released");
    c_preload: cover property ($rose(superLvl));
    c_pulse: cover property ($rose(globalClk) && !superLvl);
    c_drive: cover property (devOe != '0);
endmodule : pld_link_monitor

//--- tb/tb_top.sv
// Self-checking bench: the device and the board tester joined by the pin link.
// Assumes pld_pkg, pld_link_if, both design ends and the link monitor compile first.
`timescale 1ns/1ps
module tb_top;
    import pld_pkg::*;
    typedef struct packed {logic pol; logic in0; logic drv; cell_vec_t pins;} row_s;
    localparam fuse_row_t OPEN = '1;
    logic mclk = 1'h0;
    logic srst = 1'h1;
    logic progWrite = 1'h0;
    logic progRead = 1'h0;
    logic clockReq = 1'h0;
    logic preloadReq = 1'h0;
    logic secured;
    logic preloadActive;
    logic busy;
    cell_vec_t sampledPins;
    addr_t progAddr = '0;
    fuse_row_t progWData = '0;
    fuse_row_t progRData;
    fuse_row_t word;
    in_vec_t inputsValue = '0;
    cell_vec_t preloadValue = '0;
    cell_vec_t preloadMask = '0;
    cell_vec_t userDrive = '0;
    cell_vec_t userDriveEn = 10'h004;
    int n_fail = 0;
    int compares = 0;
    int cycles = 0;
    int progRows [7] = '{0, 1, 9, 10, 27, 28, 36};
    // Cells 0,2,3 bypassed, 1,4 registered; cell 2 is a board-driven input
    row_s rows [4] = '{'{1'h1, 1'h1, 1'h0, 10'h003}, '{1'h1, 1'h0, 1'h1, 10'h00C},
                       '{1'h0, 1'h1, 1'h1, 10'h014}, '{1'h0, 1'h0, 1'h0, 10'h01B}};
    pld_link_if link();
    pld_device u_pld_device (.mclk(mclk), .srst(srst), .link(link.dev),
        .progWrite(progWrite), .progRead(progRead), .progAddr(progAddr),
        .progWData(progWData), .progRData(progRData), .secured(secured),
        .preloadActive(preloadActive));
    board_tester u_board_tester (.mclk(mclk), .srst(srst), .link(link.board),
        .inputsValue(inputsValue), .clockReq(clockReq), .preloadReq(preloadReq),
        .preloadValue(preloadValue), .preloadMask(preloadMask), .userDrive(userDrive),
        .userDriveEn(userDriveEn), .busy(busy), .sampledPins(sampledPins));
    pld_link_monitor u_pld_link_monitor (.mclk(mclk), .srst(srst), .inPins(link.inPins),
        .globalClk(link.globalClk), .superLvl(link.superLvl), .devOut(link.devOut),
        .devOe(link.devOe), .hostOut(link.hostOut), .hostOe(link.hostOe),
        .pinLevel(link.pinLevel));
    ////////////////////////////////////////
    initial begin
        forever #20 mclk = ~mclk;
    end
    // Hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            $display("CHECK FAILED at %0t: timeout", $time);
            final_report();
        end
    end
    ////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick
    // Strobe then a gap cycle, so no strobe is assigned twice in one step
    task automatic wr(input int a, input fuse_row_t d);
        progAddr <= addr_t'(a);
        progWData <= d;
        progWrite <= 1'h1;
        @(posedge mclk);
        progWrite <= 1'h0;
        @(posedge mclk);
    endtask : wr
    task automatic rd(input int a);
        progAddr <= addr_t'(a);
        progRead <= 1'h1;
        @(posedge mclk);
        progRead <= 1'h0;
        #1 word = progRData;
        @(posedge mclk);
    endtask : rd
    task automatic clk1();
        clockReq <= 1'h1;
        @(posedge mclk);
        clockReq <= 1'h0;
        tick(12);
    endtask : clk1
    function automatic fuse_row_t lit(input int k);
        lit = OPEN;
        lit[k] = 1'h0;
    endfunction : lit
    task automatic chkPins(input cell_vec_t got, input cell_vec_t exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: pins %h expected %h", $time, got, exp);
        end
    endtask : chkPins
    task automatic chkWord(input fuse_row_t got, input fuse_row_t exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: word %h expected %h", $time, got, exp);
        end
    endtask : chkWord
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report
    ////////////////////////////////////////
    initial begin
        tick(16);
        srst <= 1'h0;
        tick(2);
        chkPins(link.devOe, '0);
        chkWord(fuse_row_t'(secured), '0);
        rd(CFG_ADDR);
        chkWord(word, '0);
        tick(PWRUP_CYC);
        foreach (progRows[i]) begin
            wr(progRows[i], progRows[i] == 28 ? lit(13) : progRows[i] % 9 == 1 ? lit(0) : OPEN);
        end
        wr(CFG_ADDR, {22'h0, 10'h00D, 10'h3FF});
        tick(8);
        chkPins(link.pinLevel & 10'h012, '0);
        chkPins(link.devOe & 10'h004, '0);
        $display("reset test done");
        // Table rows: polarity, input, board level on cell 2, expected pins
        foreach (rows[i]) begin
            wr(CFG_ADDR, {22'h0, 10'h00D, {10{rows[i].pol}}});
            inputsValue <= {10'h000, rows[i].in0};
            userDrive <= {7'h00, rows[i].drv, 2'h0};
            tick(6);
            clk1();
            chkPins(link.pinLevel & 10'h01F, rows[i].pins);
        end
        $display("table test done");
        wr(SP_ROW, OPEN);
        wr(AR_ROW, OPEN);
        tick(6);
        clk1();
        chkPins(link.pinLevel & 10'h012, 10'h012);
        wr(AR_ROW, '0);
        tick(6);
        clk1();
        chkPins(link.pinLevel & 10'h012, '0);
        wr(AR_ROW, OPEN);
        tick(8);
        chkPins(link.pinLevel & 10'h012, 10'h012);
        wr(AR_ROW, '0);
        wr(SP_ROW, '0);
        $display("preset test done");
        preloadValue <= 10'h002;
        preloadMask <= 10'h012;
        preloadReq <= 1'h1;
        @(posedge mclk);
        preloadReq <= 1'h0;
        tick(8);
        chkPins(link.devOe, '0);
        chkWord(fuse_row_t'(preloadActive), 42'h1);
        tick(20);
        chkWord(fuse_row_t'(busy), '0);
        chkPins(link.pinLevel & 10'h012, 10'h010);
        chkPins(sampledPins & 10'h012, 10'h010);
        $display("preload test done");
        rd(10);
        chkWord(word, lit(0));
        rd(127);
        chkWord(word, '0);
        wr(SEC_ADDR, 42'h1);
        tick(2);
        chkWord(fuse_row_t'(secured), 42'h1);
        rd(10);
        chkWord(word, OPEN);
        $display("security test done");
        final_report();
    end
endmodule : tb_top
